// file: rtl/tesf_pkg.sv
// package for the timer event status flag block
package tesf_pkg;
    // ==================================================================
    // register map
    localparam logic [11:0] STATUS_OFFSET   = 12'h07c; // status flags
    localparam logic [11:0] GENERATE_OFFSET = 12'h078; // software generation
    localparam logic [11:0] MASK_OFFSET     = 12'h0c0; // interrupt mask
    localparam logic [11:0] CAPTURE0_OFFSET = 12'h090; // ch0 capture value
    localparam logic [11:0] CAPTURE_STRIDE  = 12'h004; // per channel
    localparam int          CHANNELS        = 4;
    // ==================================================================
    // field positions
    localparam int MATCH_LSB    = 0;  // ch0..ch3 match/capture flags
    localparam int OVERCAP_LSB  = 4;  // ch0..ch3 over-capture flags
    localparam int FIRST_UPD    = 8;
    localparam int SECOND_UPD   = 9;
    localparam int TRIGGER_BIT  = 10;
    localparam int BREAK_BIT    = 11;
    localparam int FLAG_WIDTH   = 12;
    // ==================================================================
    // reset values
    localparam logic [11:0] STATUS_RESET = 12'h000;
    localparam logic [11:0] MASK_RESET   = 12'h000;
    // ==================================================================
    // slave restart trigger mode
    typedef enum logic [1:0] {
        TESF_MODE_FREE    = 2'h1,
        TESF_MODE_RESTART = 2'h2
    } tesf_mode_t;
endpackage : tesf_pkg

// file: rtl/tesf_status.sv
// timer event status flags with apb slave, mask and interrupt
//
// Summary of operation
// - break event sets sticky break flag
// - trigger event sets sticky trigger flag
// - update event 2 sets second-update flag
// - counter over/underflow sets first-update flag
// - soft update sets first-update unless disabled
// - restart-mode trigger rising edge sets first-update unless disabled
// - capture while flag set sets over-capture
// - output compare match sets flag, not center-aligned
// - input capture sets channel flag
// - reading capture value clears input channel flag
// - writing zero clears flag; all reset zero
// - soft break sets flag, then drops output enable
//
// The implementer's own choice: the APB interface to the registers.
`timescale 1ns/10ps
`default_nettype none
module tesf_status
    import tesf_pkg::*;
(
    input  wire logic        clock,           // 125 MHz peripheral clock
    input  wire logic        rst_n,           // async reset, active low
    input  wire logic        psel,            // apb select
    input  wire logic        penable,         // apb access phase
    input  wire logic        pwrite,          // apb direction
    input  wire logic [11:0] paddr,           // apb byte address
    input  wire logic [31:0] pwdata,          // apb write data
    output logic      [31:0] prdata,          // apb read data
    output logic             pready,          // apb ready
    output logic             pslverr,         // apb error
    input  wire logic        breakEvent,      // external break pulse
    input  wire logic        triggerEvent,    // trigger pulse
    input  wire logic        update2Event,    // update event 2 pulse
    input  wire logic        counterWrap,     // over/underflow pulse
    input  wire logic        slaveTrigger,    // slave trigger input level
    input  wire logic [1:0]  slaveMode,       // slave mode code
    input  wire logic        updateDisable,   // update-disable setting
    input  wire logic        centerAligned,   // center-aligned counting
    input  wire logic [3:0]  channelIsInput,  // per channel direction
    input  wire logic [3:0]  compareMatch,    // counter equals compare
    input  wire logic [3:0]  captureEvent,    // capture stored pulses
    input  wire logic        outputEnableSet, // software sets main enable
    output logic             mainOutputEnable,// main output enable
    output logic [3:0]       captureRead,     // capture register was read
    output logic             firstUpdateSoft, // soft update pulse out
    output logic             irq              // level interrupt
);
    // ==================================================================
    // state
    logic [11:0] flags;
    logic [11:0] mask;
    logic        slaveTrigLast;
    logic        breakPending;

    // ==================================================================
    // bus decode
    wire access     = psel & penable;
    wire wrAccess   = access & pwrite;
    wire rdAccess   = access & ~pwrite;
    wire hitStatus  = (paddr == STATUS_OFFSET);
    wire hitGen     = (paddr == GENERATE_OFFSET);
    wire hitMask    = (paddr == MASK_OFFSET);

    // capture reads are observed here; the data comes from the channels
    function automatic logic isCapture(input logic [11:0] a, input int ch);
        isCapture = (a == CAPTURE0_OFFSET + 12'(ch) * CAPTURE_STRIDE);
    endfunction : isCapture

    logic [3:0] hitCapture;
    always_comb begin
        for (int ch = 0; ch < CHANNELS; ch++) begin
            hitCapture[ch] = isCapture(paddr, ch);
        end
    end
    wire mapped = hitStatus | hitGen | hitMask | (|hitCapture);

    // ==================================================================
    // software generation strobes (self clearing by nature)
    wire genWrite   = wrAccess & hitGen;
    wire softBreak  = genWrite & pwdata[BREAK_BIT];
    wire softTrig   = genWrite & pwdata[TRIGGER_BIT];
    wire softUpd2   = genWrite & pwdata[SECOND_UPD];
    wire softUpd1   = genWrite & pwdata[FIRST_UPD];
    wire [3:0] softCc = genWrite ? pwdata[3:0] : 4'h0;

    // ==================================================================
    // event sources
    wire slaveRise  = slaveTrigger & ~slaveTrigLast;
    wire upd1Event  = counterWrap
                    | (softUpd1 & ~updateDisable)
                    | (slaveRise & (slaveMode == TESF_MODE_RESTART)
                       & ~updateDisable);
    // output match ignored in center-aligned mode
    wire [3:0] outMatch = compareMatch & ~channelIsInput
                        & {4{~centerAligned}};
    wire [3:0] inCapture = (captureEvent | softCc) & channelIsInput;
    wire [3:0] ccSet     = outMatch | inCapture | (softCc & ~channelIsInput);
    // over-capture needs the flag already standing
    wire [3:0] ocSet = inCapture & flags[MATCH_LSB +: 4];

    wire [11:0] setVec = {breakEvent | softBreak,
                          triggerEvent | softTrig,
                          update2Event | softUpd2,
                          upd1Event,
                          ocSet,
                          ccSet};

    // ==================================================================
    // clears: write zero, or capture read of an input channel
    wire [11:0] wrClear = (wrAccess & hitStatus)
                        ? ~pwdata[11:0] : 12'h000;
    wire [3:0]  rdClear = (rdAccess ? hitCapture : 4'h0)
                        & channelIsInput;
    wire [11:0] clrVec  = wrClear | {8'h00, rdClear};
    // set beats clear; writing one clears nothing
    wire [11:0] next_flags = (flags & ~clrVec) | setVec;

    // ==================================================================
    // read mux; reserved bits read zero
    wire [31:0] readData = hitStatus ? {20'h00000, flags}
                         : hitMask   ? {20'h00000, mask}
                         : 32'h00000000;

    // ==================================================================
    // flags and mask
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            flags <= STATUS_RESET;
            mask  <= MASK_RESET;
        end else begin
            flags <= next_flags;
            if (wrAccess & hitMask) begin
                mask <= pwdata[11:0];
            end
        end
    end

    // ==================================================================
    // edge detection of slave trigger input (already synchronous)
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            slaveTrigLast <= 1'b0;
        end else begin
            slaveTrigLast <= slaveTrigger;
        end
    end

    // ==================================================================
    // main output enable: flag is set first, enable drops one cycle later
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            breakPending     <= 1'b0;
            mainOutputEnable <= 1'b0;
        end else begin
            breakPending <= softBreak | breakEvent;
            if (breakPending) begin
                mainOutputEnable <= 1'b0;
            end else if (outputEnableSet) begin
                mainOutputEnable <= 1'b1;
            end
        end
    end

    // ==================================================================
    // bus answer: zero wait states, error on unmapped address
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            prdata  <= 32'h00000000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel & ~penable;
            pslverr <= psel & ~penable & ~mapped;
            prdata  <= (psel & ~penable & ~pwrite) ? readData : 32'h00000000;
        end
    end

    // ==================================================================
    // registered side outputs and interrupt
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            captureRead     <= 4'h0;
            firstUpdateSoft <= 1'b0;
            irq             <= 1'b0;
        end else begin
            captureRead     <= rdAccess ? hitCapture : 4'h0;
            firstUpdateSoft <= softUpd1 & ~updateDisable;
            irq             <= |(next_flags & mask);
        end
    end
endmodule : tesf_status
`default_nettype wire

// file: tb/tesf_checker.sv
// assertion checker for the timer event status flag block
`timescale 1ns/10ps
`default_nettype none
module tesf_checker
    import tesf_pkg::*;
(
    input wire logic        clock,            // peripheral clock
    input wire logic        rst_n,            // async reset
    input wire logic        psel,             // apb select
    input wire logic        penable,          // apb access
    input wire logic        pwrite,           // apb direction
    input wire logic [11:0] paddr,            // apb address
    input wire logic [31:0] pwdata,           // apb write data
    input wire logic [31:0] prdata,           // apb read data
    input wire logic        pready,           // apb ready
    input wire logic        pslverr,          // apb error
    input wire logic        breakEvent,       // break pulse
    input wire logic        updateDisable,    // update disable
    input wire logic        mainOutputEnable, // output enable
    input wire logic [3:0]  captureRead,      // capture read pulses
    input wire logic        firstUpdateSoft   // soft update pulse
);
    // ==========================================================
    // decode helpers
    wire logic acc  = psel && penable;
    wire logic capA = paddr[11:4] == 8'h09 && paddr[1:0] == 2'h0;
    wire logic softU = acc && pwrite && paddr == GENERATE_OFFSET
                       && pwdata[FIRST_UPD] && !updateDisable;
    wire logic mapped = capA || paddr == STATUS_OFFSET
                        || paddr == GENERATE_OFFSET || paddr == MASK_OFFSET;
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);
    chk_ready_setup: assert property (psel && !penable |=> pready)
        else $error("no ready after setup");
    chk_ready_access: assert property (pready |-> acc)
        else $error("ready outside access");
    chk_error_map: assert property (pready |-> pslverr == !mapped)
        else $error("error flag wrong for address");
    chk_reserved_zero: assert property (pready && !pwrite |-> prdata[31:12] == 20'h0)
        else $error("reserved bits not zero");
    chk_capread_pulse: assert property (acc && !pwrite && capA |=> captureRead == 4'h1 << $past(paddr[3:2]))
        else $error("capture read pulse missing");
    chk_capread_cause: assert property (captureRead != 4'h0 |-> $past(acc && !pwrite && capA))
        else $error("capture read pulse without read");
    chk_soft_update: assert property (softU |=> firstUpdateSoft)
        else $error("soft update pulse missing");
    chk_soft_cause: assert property (firstUpdateSoft |-> $past(softU))
        else $error("soft update pulse unexpected");
    chk_break_oe: assert property (breakEvent |-> ##3 !mainOutputEnable)
        else $error("output enable kept after break");
    cover property (pready && pslverr);
    cover property (captureRead != 4'h0);
    cover property (softU ##1 firstUpdateSoft);
endmodule : tesf_checker
`default_nettype wire

// file: tb/tesf_status_tb.sv
// self-checking bench for the timer event status flag block
`timescale 1ns/10ps
`default_nettype none
module tesf_status_tb
    import tesf_pkg::*;
;
    logic clock, rst_n, psel, penable, pwrite, pready, pslverr, irq, perr;
    logic breakEvent, triggerEvent, update2Event, counterWrap, slaveTrigger;
    logic updateDisable, centerAligned, outputEnableSet, mainOutputEnable;
    logic firstUpdateSoft;
    logic [1:0] slaveMode;
    logic [3:0] channelIsInput, compareMatch, captureEvent, captureRead;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, q;
    int error_cnt, checked;
    tesf_status u_tesf_status (.*);
    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic give_verdict();
        $display("compares %0d mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : give_verdict
    // apb transfer, waits for pready with a bound
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) begin
            error_cnt++;
            give_verdict();
        end
        q = prdata;
        perr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // one idle edge so the next call never reassigns psel in this step
        @(posedge clock);
    endtask : apb
    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(q, e);
    endtask : rd
    // one edge, then drop every event pulse
    task automatic tick();
        @(posedge clock);
        {breakEvent, triggerEvent, update2Event, counterWrap} <= 4'h0;
        {compareMatch, captureEvent, outputEnableSet} <= 9'h0;
    endtask : tick
    initial begin
        {error_cnt, checked, rst_n, psel, penable, pwrite, paddr} = 0;
        {breakEvent, triggerEvent, update2Event, counterWrap} = 4'h0;
        {compareMatch, captureEvent, outputEnableSet, pwdata} = 0;
        {slaveTrigger, updateDisable, centerAligned} = 3'h0;
        slaveMode = TESF_MODE_FREE;
        channelIsInput = 4'h3;
        repeat (5) @(posedge clock);
        rst_n <= 1'b1;
        rd(STATUS_OFFSET, 32'h0);
        {breakEvent, triggerEvent, update2Event, counterWrap} <= 4'hf;
        tick();
        rd(STATUS_OFFSET, 32'hf00);
        apb(1'b1, STATUS_OFFSET, 32'hffff_feff);
        rd(STATUS_OFFSET, 32'he00);
        apb(1'b1, STATUS_OFFSET, 32'h0);
        updateDisable <= 1'b1;
        apb(1'b1, GENERATE_OFFSET, 32'h100);
        rd(STATUS_OFFSET, 32'h0);
        updateDisable <= 1'b0;
        apb(1'b1, GENERATE_OFFSET, 32'h100);
        rd(STATUS_OFFSET, 32'h100);
        apb(1'b1, STATUS_OFFSET, 32'h0);
        slaveTrigger <= 1'b1;
        tick();
        slaveTrigger <= 1'b0;
        tick();
        rd(STATUS_OFFSET, 32'h0);
        slaveMode <= TESF_MODE_RESTART;
        slaveTrigger <= 1'b1;
        tick();
        rd(STATUS_OFFSET, 32'h100);
        $display("update tests done");
        apb(1'b1, STATUS_OFFSET, 32'h0);
        compareMatch <= 4'hf;
        tick();
        rd(STATUS_OFFSET, 32'h00c);
        centerAligned <= 1'b1;
        apb(1'b1, STATUS_OFFSET, 32'h0);
        compareMatch <= 4'hf;
        tick();
        captureEvent <= 4'h3;
        tick();
        captureEvent <= 4'h1;
        tick();
        rd(STATUS_OFFSET, 32'h013);
        rd(CAPTURE0_OFFSET, 32'h0);
        rd(STATUS_OFFSET, 32'h012);
        $display("channel tests done");
        apb(1'b1, STATUS_OFFSET, 32'h0);
        apb(1'b1, MASK_OFFSET, 32'h800);
        triggerEvent <= 1'b1;
        outputEnableSet <= 1'b1;
        tick();
        #1 chk(irq, 32'h0);
        chk(mainOutputEnable, 32'h1);
        apb(1'b1, GENERATE_OFFSET, 32'h800);
        repeat (3) @(posedge clock);
        #1 chk(irq, 32'h1);
        chk(mainOutputEnable, 32'h0);
        apb(1'b1, STATUS_OFFSET, 32'hffff_f7ff);
        rd(STATUS_OFFSET, 32'h400);
        chk(irq, 32'h0);
        apb(1'b0, 12'h100, 32'h0);
        chk({31'h0, perr}, 32'h1);
        chk(q, 32'h0);
        $display("irq and bus tests done");
        give_verdict();
    end
endmodule : tesf_status_tb
bind tesf_status tesf_checker u_tesf_checker (.*);
`default_nettype wire
